/* rtl/rd_burst_pkg.sv */
// Shared constants and carrier types of the read-burst control block.
// Assumes one 32-bit register port on clk and a command link on the link clock.
package rd_burst_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CFG = 8'h00;
  localparam logic [7:0] ADDR_STAT = 8'h04;

  // Configuration and status field positions
  localparam int CFG_BL_LSB = 0;
  localparam int CFG_PRE2_BIT = 2;
  localparam int CFG_CL_LSB = 8;
  localparam int CFG_AL_LSB = 16;
  localparam int STAT_BUSY_BIT = 16;

  // Burst-length field codes
  localparam logic [1:0] BL_FIXED8 = 2'h0;
  localparam logic [1:0] BL_OTF = 2'h1;
  localparam logic [1:0] BL_FIXED4 = 2'h2;

  // Reset values
  localparam logic [4:0] CL_RST = 5'h0b;
  localparam logic [4:0] AL_RST = 5'h00;

  // Burst geometry, counted in link clocks (two beats per clock)
  localparam logic [1:0] LAST_CLK_BL8 = 2'h3;
  localparam logic [1:0] LAST_CLK_BC4 = 2'h1;
  localparam int PIPE_DEPTH = 64;
  localparam int A10_BIT = 10;
  localparam int A12_BIT = 12;

  typedef struct packed {
    logic [1:0] bl_mode;
    logic pre2;
    logic [4:0] cl;
    logic [4:0] al;
  } cfg_t;

  typedef struct packed {
    logic vld;
    logic bc4;
    logic ap;
    logic [3:0] bank;
    logic [9:0] col;
  } cmd_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_PRE = 3'b010,
    ST_DATA = 3'b100
  } lstate_t;

endpackage

/* rtl/ddr_sdram_read_burst_control.sv */
// Read-burst command handling of the memory device: command decode, read
// latency, burst length selection, strobe preamble, auto precharge.
// Assumes: clk/srst register side; ck is the controller's command clock and
// commands arrive synchronous to it; pins are resolved outside from enables.
//
// Contract
// - Supports fixed eight, fixed chop four, on-the-fly
// - On-the-fly: A12 low chops, high gives eight
// - A10 low read leaves bank open
// - A10 high read precharges bank after burst
// - Field 00 always eight beats
// - Field 01 takes length from A12 per command
// - Field 10 always four beats chopped
`timescale 1ns/10ps
`default_nettype none

module ddr_sdram_read_burst_control (
  // Register side clock and reset
  input wire logic clk,
  input wire logic srst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Command link
  input wire logic ck,
  input wire logic cmd_rd,
  input wire logic cmd_act,
  input wire logic cmd_pre,
  input wire logic [3:0] cmd_bank,
  input wire logic [13:0] cmd_addr,
  // Data and strobe pins
  output logic [15:0] dq_o,
  output logic dq_oe,
  output logic dqs_o,
  output logic dqs_oe
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic chop_sel(
    input logic [1:0] mode,
    input logic a12);
    case (mode)
      rd_burst_pkg::BL_FIXED8: chop_sel = 1'b0;
      rd_burst_pkg::BL_OTF: chop_sel = ~a12;
      rd_burst_pkg::BL_FIXED4: chop_sel = 1'b1;
      default: chop_sel = 1'b0;
    endcase
  endfunction

  // Read word: beat index and a marker bit above the column
  function automatic logic [15:0] beat_word(
    input logic [9:0] col,
    input logic [1:0] clk_idx
  );
    beat_word = {3'h0, clk_idx, 1'b1, col};
  endfunction

  // ----------------------------------------------------------------
  // Register side
  // ----------------------------------------------------------------
  rd_burst_pkg::cfg_t cfg_r;
  logic cfg_tgl_r;
  logic [31:0] reg_rdata_r;
  logic [16:0] stat_s1_r;
  logic [16:0] stat_s2_r;
  wire logic wr_cfg = reg_wr && (reg_addr == rd_burst_pkg::ADDR_CFG);
  wire logic [31:0] cfg_word = {11'h000, cfg_r.al, 3'h0, cfg_r.cl, 5'h00,
                                cfg_r.pre2, cfg_r.bl_mode};
  wire logic [31:0] stat_word = {15'h0000, stat_s2_r};
  wire logic [31:0] rd_mux = (reg_addr == rd_burst_pkg::ADDR_CFG) ? cfg_word :
                             (reg_addr == rd_burst_pkg::ADDR_STAT) ? stat_word : 32'h0;

  always_ff @(posedge clk) begin
    if (srst) begin
      cfg_r <= '{bl_mode: rd_burst_pkg::BL_FIXED8, pre2: 1'b0,
                 cl: rd_burst_pkg::CL_RST, al: rd_burst_pkg::AL_RST};
    end else if (wr_cfg) begin
      cfg_r.bl_mode <= reg_wdata[rd_burst_pkg::CFG_BL_LSB +: 2];
      cfg_r.pre2 <= reg_wdata[rd_burst_pkg::CFG_PRE2_BIT];
      cfg_r.cl <= reg_wdata[rd_burst_pkg::CFG_CL_LSB +: 5];
      cfg_r.al <= reg_wdata[rd_burst_pkg::CFG_AL_LSB +: 5];
    end
  end

  // Toggle marks each new configuration for the link side
  always_ff @(posedge clk) begin
    if (srst) begin
      cfg_tgl_r <= 1'b0;
    end else if (wr_cfg) begin
      cfg_tgl_r <= ~cfg_tgl_r;
    end
  end

  // Read data stands one cycle, zero otherwise
  always_ff @(posedge clk) begin
    if (srst) begin
      reg_rdata_r <= 32'h0;
    end else begin
      reg_rdata_r <= reg_rd ? rd_mux : 32'h0;
    end
  end
  assign reg_rdata = reg_rdata_r;

  // ----------------------------------------------------------------
  // Link domain reset and configuration crossing
  // ----------------------------------------------------------------
  logic lrst_s1_r;
  logic lrst_r;
  logic tgl_s1_r;
  logic tgl_s2_r;
  logic tgl_s3_r;
  rd_burst_pkg::cfg_t lcfg_r;

  // Reset reaches the link side through two flops
  always_ff @(posedge ck) begin
    lrst_s1_r <= srst;
    lrst_r <= lrst_s1_r;
  end

  // Config toggle synchroniser and its edge detector flop
  always_ff @(posedge ck) begin
    tgl_s1_r <= cfg_tgl_r;
    tgl_s2_r <= tgl_s1_r;
    tgl_s3_r <= tgl_s2_r;
  end

  // Config word is held stable in clk domain; toggle marks it as settled
  always_ff @(posedge ck) begin
    if (lrst_r) begin
      lcfg_r <= '{bl_mode: rd_burst_pkg::BL_FIXED8, pre2: 1'b0,
                  cl: rd_burst_pkg::CL_RST, al: rd_burst_pkg::AL_RST};
    end else if (tgl_s2_r != tgl_s3_r) begin
      lcfg_r <= cfg_r;
    end
  end

  // ----------------------------------------------------------------
  // Read latency pipeline
  // ----------------------------------------------------------------
  // Slot k holds the command taken k+1 link clocks ago
  rd_burst_pkg::cmd_t pipe_r [rd_burst_pkg::PIPE_DEPTH];
  wire rd_burst_pkg::cmd_t cmd_in = '{vld: cmd_rd,
    bc4: chop_sel(lcfg_r.bl_mode, cmd_addr[rd_burst_pkg::A12_BIT]),
    ap: cmd_addr[rd_burst_pkg::A10_BIT], bank: cmd_bank, col: cmd_addr[9:0]};
  wire logic [5:0] rl = {1'b0, lcfg_r.al} + {1'b0, lcfg_r.cl};
  wire logic [5:0] pre_len = lcfg_r.pre2 ? 6'h02 : 6'h01;
  wire logic [5:0] tap_d_idx = rl - 6'h01;
  // Preamble tap leads the data tap by the preamble length
  wire logic [5:0] tap_p_idx = rl - 6'h01 - pre_len;
  wire rd_burst_pkg::cmd_t tap_d = pipe_r[tap_d_idx];
  wire rd_burst_pkg::cmd_t tap_p = pipe_r[tap_p_idx];

  always_ff @(posedge ck) begin
    if (lrst_r) begin
      for (int i = 0; i < rd_burst_pkg::PIPE_DEPTH; i++) pipe_r[i] <= '0;
    end else begin
      pipe_r[0] <= cmd_in;
      for (int i = 1; i < rd_burst_pkg::PIPE_DEPTH; i++) pipe_r[i] <= pipe_r[i-1];
    end
  end

  // ----------------------------------------------------------------
  // Burst sequencer
  // ----------------------------------------------------------------
  rd_burst_pkg::lstate_t st_r;
  rd_burst_pkg::lstate_t st_nxt;
  rd_burst_pkg::cmd_t cur_r;
  logic [1:0] clk_idx_r;
  logic [15:0] bank_open_r;
  logic [15:0] dq_r;
  logic dq_oe_r;
  logic dqs_r;
  logic dqs_oe_r;
  wire logic [1:0] last_idx = cur_r.bc4 ? rd_burst_pkg::LAST_CLK_BC4
                                        : rd_burst_pkg::LAST_CLK_BL8;
  wire logic burst_end = (st_r == rd_burst_pkg::ST_DATA) && (clk_idx_r == last_idx);

  always_comb begin
    st_nxt = st_r;
    case (st_r)
      rd_burst_pkg::ST_IDLE: begin
        if (tap_d.vld) st_nxt = rd_burst_pkg::ST_DATA;
        else if (tap_p.vld) st_nxt = rd_burst_pkg::ST_PRE;
      end
      rd_burst_pkg::ST_PRE: begin
        if (tap_d.vld) st_nxt = rd_burst_pkg::ST_DATA;
      end
      rd_burst_pkg::ST_DATA: begin
        if (tap_d.vld) st_nxt = rd_burst_pkg::ST_DATA;
        else if (burst_end) begin
          st_nxt = tap_p.vld ? rd_burst_pkg::ST_PRE : rd_burst_pkg::ST_IDLE;
        end
      end
      default: begin
        st_nxt = rd_burst_pkg::ST_IDLE;
      end
    endcase
  end

  // Burst state
  always_ff @(posedge ck) begin
    if (lrst_r) begin
      st_r <= rd_burst_pkg::ST_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Current burst and its beat index; a new command restarts both
  always_ff @(posedge ck) begin
    if (lrst_r) begin
      cur_r <= '0;
      clk_idx_r <= 2'h0;
    end else if (tap_d.vld) begin
      cur_r <= tap_d;
      clk_idx_r <= 2'h0;
    end else if (st_r == rd_burst_pkg::ST_DATA) begin
      clk_idx_r <= clk_idx_r + 2'h1;
    end
  end

  // Bank state: activate opens, precharge or auto precharge closes
  always_ff @(posedge ck) begin
    if (lrst_r) begin
      bank_open_r <= 16'h0000;
    end else begin
      if (burst_end && cur_r.ap) bank_open_r[cur_r.bank] <= 1'b0;
      if (cmd_pre) bank_open_r[cmd_bank] <= 1'b0;
      if (cmd_act) bank_open_r[cmd_bank] <= 1'b1;
    end
  end

  // Pin drivers: data only in data clocks, strobe low through preamble
  wire logic data_now = (st_nxt == rd_burst_pkg::ST_DATA);
  wire logic [1:0] idx_nxt = tap_d.vld ? 2'h0 : clk_idx_r + 2'h1;
  wire rd_burst_pkg::cmd_t src_cmd = tap_d.vld ? tap_d : cur_r;

  always_ff @(posedge ck) begin
    if (lrst_r) begin
      dq_oe_r <= 1'b0;
    end else begin
      dq_oe_r <= data_now;
    end
  end

  always_ff @(posedge ck) begin
    if (lrst_r) begin
      dq_r <= 16'h0000;
    end else begin
      dq_r <= data_now ? beat_word(src_cmd.col, idx_nxt) : 16'h0000;
    end
  end

  always_ff @(posedge ck) begin
    if (lrst_r) begin
      dqs_oe_r <= 1'b0;
    end else begin
      dqs_oe_r <= (st_nxt != rd_burst_pkg::ST_IDLE);
    end
  end

  always_ff @(posedge ck) begin
    if (lrst_r) begin
      dqs_r <= 1'b0;
    end else begin
      dqs_r <= data_now;
    end
  end

  assign dq_o = dq_r;
  assign dq_oe = dq_oe_r;
  assign dqs_o = dqs_r;
  assign dqs_oe = dqs_oe_r;

  // ----------------------------------------------------------------
  // Status back to the register side
  // ----------------------------------------------------------------
  logic busy_r;
  always_ff @(posedge ck) begin
    if (lrst_r) begin
      busy_r <= 1'b0;
    end else begin
      busy_r <= (st_nxt != rd_burst_pkg::ST_IDLE);
    end
  end

  // Status crosses as quasi-static levels, read only when settled
  always_ff @(posedge clk) begin
    stat_s1_r <= {busy_r, bank_open_r};
    stat_s2_r <= stat_s1_r;
  end

endmodule // ddr_sdram_read_burst_control

`default_nettype wire

/* bench/rd_burst_asserts.sv */
// Checker of the read data and strobe pins on the link clock.
// Assumes it is bound into the block and sees only its ports.
`timescale 1ns/10ps
`default_nettype none
module rd_burst_asserts (
  // Register side reset and link clock
  input wire logic srst,
  input wire logic ck,
  // Data and strobe pins
  input wire logic [15:0] dq_o,
  input wire logic dq_oe,
  input wire logic dqs_o,
  input wire logic dqs_oe
);
  default clocking cb @(posedge ck);
  endclocking
  default disable iff (srst);
  sequence s_pre;
    dqs_oe && !dq_oe;
  endsequence
  sequence s_chop;
    $rose(dq_oe) ##1 dq_oe ##1 !dq_oe;
  endsequence
  AST_DATA_STROBE: assert property (dq_oe |-> dqs_oe && dqs_o)
    else $error("data without strobe");
  AST_PRE_LOW: assert property (s_pre |-> !dqs_o)
    else $error("strobe high in preamble");
  AST_PRE_FIRST: assert property ($rose(dq_oe) |-> $past(dqs_oe))
    else $error("data without preamble");
  AST_TWO_MIN: assert property ($rose(dq_oe) |=> dq_oe)
    else $error("burst shorter than two clocks");
  AST_WORD_FORM: assert property (dq_oe |-> dq_o[15:13] == 3'h0 && dq_o[10])
    else $error("bad word form");
  AST_BEAT_ZERO: assert property ($rose(dq_oe) |-> dq_o[12:11] == 2'h0)
    else $error("burst not starting at beat zero");
  AST_BEAT_STEP: assert property (dq_oe && $past(dq_oe) && dq_o[12:11] != 2'h0 |->
    dq_o[12:11] == $past(dq_o[12:11]) + 2'h1 && dq_o[9:0] == $past(dq_o[9:0]))
    else $error("beat order broken");
  AST_BURST_END: assert property ($fell(dq_oe) |->
    $past(dq_o[12:11]) == 2'h1 || $past(dq_o[12:11]) == 2'h3)
    else $error("burst ended mid way");
  AST_RELEASE: assert property ($fell(dq_oe) && dqs_oe |-> !dqs_o ##2 dq_oe)
    else $error("strobe held after data");
  AST_IDLE_QUIET: assert property (!dqs_oe |-> !dq_oe && !dqs_o)
    else $error("data or strobe driven while released");
  COV_CHOP: cover property (s_chop);
endmodule // rd_burst_asserts

bind ddr_sdram_read_burst_control rd_burst_asserts chk_u (.srst(srst), .ck(ck), .dq_o(dq_o),
  .dq_oe(dq_oe), .dqs_o(dqs_o), .dqs_oe(dqs_oe));
`default_nettype wire

/* bench/mem_ctrl_model.sv */
// Controller model: issues commands on the link clock, captures read words.
// Assumes the bench calls issue() and reads the capture queues.
`timescale 1ns/10ps
`default_nettype none
module mem_ctrl_model (
  // Link clock
  input wire logic ck,
  // Commands
  output logic cmd_rd,
  output logic cmd_act,
  output logic cmd_pre,
  output logic [3:0] cmd_bank,
  output logic [13:0] cmd_addr,
  // Pins
  input wire logic [15:0] dq_o,
  input wire logic dq_oe,
  input wire logic dqs_oe
);
  int cyc = 0;
  int t_cmd = 0;
  int rise_q[$];
  int dqs_q[$];
  logic dq_oe_q = 1'b0;
  logic dqs_oe_q = 1'b0;
  logic [15:0] words[$];
  initial {cmd_rd, cmd_act, cmd_pre, cmd_bank, cmd_addr} = '0;
  always @(posedge ck) begin
    cyc <= cyc + 1;
    dq_oe_q <= dq_oe;
    dqs_oe_q <= dqs_oe;
    if (dq_oe === 1'b1) words.push_back(dq_o);
    if (dq_oe === 1'b1 && dq_oe_q === 1'b0) rise_q.push_back(cyc);
    if (dqs_oe === 1'b1 && dqs_oe_q === 1'b0) dqs_q.push_back(cyc);
  end
  // Kind 0 activate, 1 precharge, 2 read; held for one clock
  // No write commands are issued, so no write latency margin is needed
  task automatic issue(input int kind, input logic [3:0] bank, input logic [13:0] addr);
    @(posedge ck);
    cmd_act <= (kind == 0);
    cmd_pre <= (kind == 1);
    cmd_rd <= (kind == 2);
    cmd_bank <= bank;
    cmd_addr <= addr;
    @(posedge ck);
    t_cmd = cyc;
    {cmd_rd, cmd_act, cmd_pre} <= 3'h0;
    cmd_addr <= ~addr;
  endtask
endmodule // mem_ctrl_model
`default_nettype wire

/* bench/ddr_sdram_read_burst_control_bench.sv */
// Bench: random read pairs against a queue model of the burst rules.
// Assumes the controller model and the bound checker.
`timescale 1ns/10ps
`default_nettype none
module ddr_sdram_read_burst_control_bench;
  logic clk = 1'b0;
  logic ck = 1'b0;
  logic srst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic cmd_rd, cmd_act, cmd_pre, dq_oe, dqs_o, dqs_oe;
  logic [3:0] cmd_bank;
  logic [13:0] cmd_addr;
  logic [15:0] dq_o;
  logic [15:0] open_m = 16'h0;
  logic [15:0] exp_q[$];
  int errors = 0;
  int num_checks = 0;
  always #2.5 clk = ~clk;
  always #24 ck = ~ck;
  ddr_sdram_read_burst_control dut_u (.clk, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .ck, .cmd_rd, .cmd_act, .cmd_pre, .cmd_bank, .cmd_addr, .dq_o, .dq_oe,
    .dqs_o, .dqs_oe);
  mem_ctrl_model mem_u (.ck, .cmd_rd, .cmd_act, .cmd_pre, .cmd_bank, .cmd_addr, .dq_o,
    .dq_oe, .dqs_oe);
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d, errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic reg_access(input logic wr, input logic [7:0] a, input logic [31:0] wd,
    output logic [31:0] rd);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= wd;
    reg_wr <= wr;
    reg_rd <= !wr;
    @(posedge clk);
    {reg_wr, reg_rd} <= 2'h0;
    #1;
    rd = reg_rdata;
    @(posedge clk);
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] d;
    logic [4:0] al, cl;
    logic [1:0] mode;
    logic [3:0] b;
    logic [9:0] col;
    logic pre2, a12, ap, bc4;
    int t1, gap;
    void'($urandom(81));
    repeat (5) @(posedge ck);
    @(posedge clk);
    srst <= 1'b0;
    repeat (4) @(posedge ck);
    reg_access(1'b0, rd_burst_pkg::ADDR_STAT, 32'h0, d);
    check("stat reset", d, 32'h0);
    reg_access(1'b0, 8'h08, 32'h0, d);
    check("unmapped", d, 32'h0);
    for (int i = 0; i < 32; i++) begin
      mode = 2'(i % 4);
      al = 5'($urandom_range(10));
      cl = 5'(9 + $urandom_range(11));
      pre2 = 1'($urandom);
      reg_access(1'b1, rd_burst_pkg::ADDR_CFG, {11'h0, al, 3'h0, cl, 5'h0, pre2, mode}, d);
      repeat (6) @(posedge ck);
      b = 4'($urandom);
      mem_u.issue(0, b, 14'h0);
      open_m[b] = 1'b1;
      gap = $urandom_range(1) ? 4 : 6;
      for (int r = 0; r < 2; r++) begin
        a12 = 1'($urandom);
        col = 10'($urandom);
        ap = (r == 1) && 1'($urandom);
        bc4 = mode == rd_burst_pkg::BL_FIXED4 || (mode == rd_burst_pkg::BL_OTF && !a12);
        for (int k = 0; k < (bc4 ? 2 : 4); k++) exp_q.push_back({3'h0, 2'(k), 1'b1, col});
        mem_u.issue(2, b, {1'b0, a12, 1'b0, ap, col});
        if (r == 0) t1 = mem_u.t_cmd;
        if (r == 0) repeat (gap - 2) @(posedge ck);
      end
      if (ap) open_m[b] = 1'b0;
      repeat (al + cl + 12) @(posedge ck);
      check("word count", mem_u.words.size(), exp_q.size());
      foreach (exp_q[j]) check("word", mem_u.words[j], exp_q[j]);
      check("latency", mem_u.rise_q[0] - t1, al + cl + 1);
      check("preamble", mem_u.rise_q[0] - mem_u.dqs_q[0], pre2 + 1);
      reg_access(1'b0, rd_burst_pkg::ADDR_STAT, 32'h0, d);
      check("stat", d, {16'h0, open_m});
      if (!ap) mem_u.issue(1, b, 14'h0);
      open_m[b] = 1'b0;
      mem_u.words.delete();
      exp_q.delete();
      mem_u.rise_q.delete();
      mem_u.dqs_q.delete();
    end
    end_sim();
  end
  initial begin
    #400000;
    errors++;
    end_sim();
  end
endmodule // ddr_sdram_read_burst_control_bench
`default_nettype wire
